/* inc/serial_status_defines.svh */
/*
  Offsets, field positions, reset values and timing counts for the
  second serial status register block.
  Assumes inclusion by bare name from the design file; the package does not include it.
*/
`ifndef SERIAL_STATUS_DEFINES_SVH
`define SERIAL_STATUS_DEFINES_SVH

// ==========================================================
// Register offsets (byte addresses on the plain port)
`define SS_OFF_STATUS2      8'h00
`define SS_OFF_CTRL         8'h01

// ==========================================================
// Field positions in the status register
`define SS_BIT_BRK_FLAG     7
`define SS_BIT_EDGE_FLAG    6
`define SS_BIT_RX_INV       4
`define SS_BIT_WAKE_IDLE    3
`define SS_BIT_LONG_BRK     1
`define SS_BIT_RX_ACTIVE    0

// Field positions in the control register
`define SS_BIT_NINE_BIT     0
`define SS_BIT_BRK_ON       1

// ==========================================================
// Reset values
`define SS_RST_STATUS2      8'h00
`define SS_RST_CTRL         8'h00

// ==========================================================
// Break and idle lengths in bit times
`define SS_BRK_BITS_SHORT   10
`define SS_BRK_BITS_NINE    11
`define SS_BRK_BITS_LONG    11
`define SS_BRK_BITS_LONG9   12
`define SS_CHAR_BITS        10
`define SS_CHAR_BITS_NINE   11

// ==========================================================
// Timing
`define SS_CLK_PERIOD_NS    10
`define SS_BIT_TIME_NS      8680
`define SS_BIT_CLKS         ((`SS_BIT_TIME_NS) / (`SS_CLK_PERIOD_NS))

`endif

/* inc/serial_status_pkg.sv */
/*
  Types shared by the second serial status register block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package serial_status_pkg;

  // ==========================================================
  // Register port request, one cycle per access
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bus_req_t;

  // ==========================================================
  // Receiver activity tracking
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_START  = 2'b01,
    ST_ACTIVE = 2'b10
  } rx_state_t;

endpackage : serial_status_pkg

/* src/serial_status_two_flags.sv */
/*
  Second serial status register: break and receive-edge event flags,
  receive polarity control, long-break select and receiver-active flag.
  Assumes a synchronous receive pin, one clock, and a plain register port
  whose read data appear in the cycle after the read strobe.
*/
`timescale 1ns/1ps
`include "serial_status_defines.svh"

module serial_status_two_flags #(
  parameter int BIT_CLKS = `SS_BIT_CLKS
) (
  input  wire logic                      i_clk,
  input  wire logic                      i_rst_n,
  input  wire logic                      i_ce,
  input  wire serial_status_pkg::bus_req_t i_bus,
  input  wire logic                      i_rxd,
  output logic [7:0]                     o_rdata,
  output logic                           o_rx_data,
  output logic                           o_err_suppress,
  output logic                           o_rx_active
);

  // ==========================================================
  // Parameter checks and widths
  localparam int MAX_CLKS = `SS_BRK_BITS_LONG9 * BIT_CLKS + 1;
  localparam int CW       = $clog2(MAX_CLKS + 1);

  // Elaboration-time refusal: half a bit must be at least one clock
  if (BIT_CLKS < 2) begin : g_bit_clks_check
    $error("BIT_CLKS must be at least 2");
  end

  // ==========================================================
  // State
  logic          brk_flag_r;
  logic          edge_flag_r;
  logic          rx_inv_r;
  logic          wake_idle_r;
  logic          long_brk_r;
  logic          nine_bit_r;
  logic          brk_on_r;
  logic          rx_prev_r;
  logic [CW-1:0] lo_cnt_r;
  logic [CW-1:0] st_cnt_r;
  logic [7:0]    rdata_r;
  logic          rx_data_r;
  logic          rx_active_r;
  serial_status_pkg::rx_state_t state_r;
  serial_status_pkg::rx_state_t state_nxt;
  logic [CW-1:0] st_cnt_nxt;

  // ==========================================================
  // Address decode
  wire wr_status = i_bus.wr && (i_bus.addr == `SS_OFF_STATUS2);
  wire wr_ctrl   = i_bus.wr && (i_bus.addr == `SS_OFF_CTRL);
  wire rd_status = i_bus.rd && (i_bus.addr == `SS_OFF_STATUS2);
  wire rd_ctrl   = i_bus.rd && (i_bus.addr == `SS_OFF_CTRL);

  // Write-one-to-clear strobes, zero bits leave the flag alone
  wire clr_brk  = wr_status && i_bus.wdata[`SS_BIT_BRK_FLAG];
  wire clr_edge = wr_status && i_bus.wdata[`SS_BIT_EDGE_FLAG];

  // ==========================================================
  // Receive data conditioning
  // Pin is xored once here so start, data, stop, break and idle all flip
  wire rx_eff  = i_rxd ^ rx_inv_r;
  // Falling of the conditioned line is a falling pin edge, or rising when inverted
  wire rx_fall = rx_prev_r && !rx_eff;

  // ==========================================================
  // Break threshold selection
  wire [CW-1:0] brk_bits = long_brk_r ?
                           (nine_bit_r ? CW'(`SS_BRK_BITS_LONG9) : CW'(`SS_BRK_BITS_LONG)) :
                           (nine_bit_r ? CW'(`SS_BRK_BITS_NINE)  : CW'(`SS_BRK_BITS_SHORT));
  wire [CW-1:0] brk_clks  = CW'(brk_bits * CW'(BIT_CLKS));
  wire [CW-1:0] char_clks = nine_bit_r ? CW'(`SS_CHAR_BITS_NINE * BIT_CLKS) :
                                         CW'(`SS_CHAR_BITS * BIT_CLKS);
  wire [CW-1:0] half_clks = CW'(BIT_CLKS / 2);

  // Counter saturates past the threshold so a long low line flags once
  wire lo_sat  = (lo_cnt_r == CW'(MAX_CLKS));
  wire brk_hit = brk_on_r && !rx_eff && (lo_cnt_r == brk_clks - CW'(1));

  // ==========================================================
  // Flag next values; a set in the clear cycle wins
  wire brk_nxt  = brk_hit || (brk_flag_r && !clr_brk);
  wire edge_nxt = rx_fall || (edge_flag_r && !clr_edge);

  // ==========================================================
  // Read mux, unmapped addresses read zero
  wire [7:0] status_word = {brk_flag_r, edge_flag_r, 1'b0, rx_inv_r,
                            wake_idle_r, 1'b0, long_brk_r, rx_active_r};
  wire [7:0] ctrl_word   = {6'h00, brk_on_r, nine_bit_r};
  wire [7:0] rdata_nxt   = rd_status ? status_word :
                           rd_ctrl   ? ctrl_word   : 8'h00;

  // ==========================================================
  // Receiver activity machine
  // Start must hold low for half a bit to count as valid
  always_comb begin
    state_nxt  = state_r;
    st_cnt_nxt = st_cnt_r;
    case (state_r)
      serial_status_pkg::ST_IDLE: begin
        st_cnt_nxt = '0;
        if (rx_fall) begin
          state_nxt = serial_status_pkg::ST_START;
        end
      end
      serial_status_pkg::ST_START: begin
        if (rx_eff) begin
          state_nxt  = serial_status_pkg::ST_IDLE;   // Glitch, not a start
          st_cnt_nxt = '0;
        end else if (st_cnt_r >= half_clks - CW'(1)) begin
          state_nxt  = serial_status_pkg::ST_ACTIVE;
          st_cnt_nxt = '0;
        end else begin
          st_cnt_nxt = st_cnt_r + CW'(1);
        end
      end
      serial_status_pkg::ST_ACTIVE: begin
        if (!rx_eff) begin
          st_cnt_nxt = '0;
        end else if (st_cnt_r >= char_clks - CW'(1)) begin
          state_nxt  = serial_status_pkg::ST_IDLE;
          st_cnt_nxt = '0;
        end else begin
          st_cnt_nxt = st_cnt_r + CW'(1);
        end
      end
      default: begin
        state_nxt  = serial_status_pkg::ST_IDLE;
        st_cnt_nxt = '0;
      end
    endcase
  end

  wire active_nxt = (state_nxt == serial_status_pkg::ST_ACTIVE);

  // ==========================================================
  // Event flags
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      brk_flag_r  <= 1'b0;
      edge_flag_r <= 1'b0;
    end else if (i_ce) begin
      brk_flag_r  <= brk_nxt;
      edge_flag_r <= edge_nxt;
    end
  end

  // ==========================================================
  // Software controls
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rx_inv_r    <= 1'b0;
      wake_idle_r <= 1'b0;
      long_brk_r  <= 1'b0;
      nine_bit_r  <= 1'b0;
      brk_on_r    <= 1'b0;
    end else if (i_ce) begin
      if (wr_status) begin
        rx_inv_r    <= i_bus.wdata[`SS_BIT_RX_INV];
        wake_idle_r <= i_bus.wdata[`SS_BIT_WAKE_IDLE];
        long_brk_r  <= i_bus.wdata[`SS_BIT_LONG_BRK];
      end
      if (wr_ctrl) begin
        nine_bit_r <= i_bus.wdata[`SS_BIT_NINE_BIT];
        brk_on_r   <= i_bus.wdata[`SS_BIT_BRK_ON];
      end
    end
  end

  // ==========================================================
  // Line tracking and low-time counter
  // Idle line is high, so the edge history starts high
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rx_prev_r <= 1'b1;
      lo_cnt_r  <= '0;
    end else if (i_ce) begin
      rx_prev_r <= rx_eff;
      if (rx_eff) begin
        lo_cnt_r <= '0;
      end else if (!lo_sat) begin
        lo_cnt_r <= lo_cnt_r + CW'(1);
      end
    end
  end

  // ==========================================================
  // Activity machine registers
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_r  <= serial_status_pkg::ST_IDLE;
      st_cnt_r <= '0;
    end else if (i_ce) begin
      state_r  <= state_nxt;
      st_cnt_r <= st_cnt_nxt;
    end
  end

  // ==========================================================
  // Registered outputs
  // Read data stand for one cycle only, zero otherwise
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rdata_r     <= 8'h00;
      rx_data_r   <= 1'b1;
      rx_active_r <= 1'b0;
    end else if (i_ce) begin
      rdata_r     <= rdata_nxt;
      rx_data_r   <= rx_eff;
      rx_active_r <= active_nxt;
    end
  end

  assign o_rdata        = rdata_r;
  assign o_rx_data      = rx_data_r;
  assign o_err_suppress = long_brk_r; // Receiver holds off framing and full flags
  assign o_rx_active    = rx_active_r;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_brk_event;
    i_ce && brk_hit;
  endsequence

  sequence s_start_valid;
    i_ce && (state_r == serial_status_pkg::ST_START) && !rx_eff &&
    (st_cnt_r >= half_clks - CW'(1));
  endsequence

  property p_brk_set;
    s_brk_event |=> brk_flag_r;
  endproperty
  a_brk_set: assert property (p_brk_set) else $error("break flag not set");

  property p_brk_needs_enable;
    (i_ce && !brk_on_r && !brk_flag_r && !(i_bus.wr && i_bus.addr == `SS_OFF_CTRL)) |=> !brk_flag_r;
  endproperty
  a_brk_needs_enable: assert property (p_brk_needs_enable) else $error("break flag set while off");

  property p_brk_w0_keep;
    (i_ce && brk_flag_r && wr_status && !i_bus.wdata[`SS_BIT_BRK_FLAG]) |=> brk_flag_r;
  endproperty
  a_brk_w0_keep: assert property (p_brk_w0_keep) else $error("break flag lost on zero write");

  property p_brk_w1_clear;
    (i_ce && clr_brk && !brk_hit) |=> !brk_flag_r;
  endproperty
  a_brk_w1_clear: assert property (p_brk_w1_clear) else $error("break flag not cleared");

  property p_edge_set;
    (i_ce && rx_prev_r && (i_rxd ^ rx_inv_r) == 1'b0) |=> edge_flag_r;
  endproperty
  a_edge_set: assert property (p_edge_set) else $error("edge flag not set");

  property p_edge_clear;
    (i_ce && edge_flag_r && clr_edge && !rx_fall) |=> !edge_flag_r ##1 (edge_flag_r == $past(rx_fall && i_ce));
  endproperty
  a_edge_clear: assert property (p_edge_clear) else $error("edge flag clear wrong");

  property p_invert;
    i_ce |=> (o_rx_data == ($past(i_rxd) ^ $past(rx_inv_r)));
  endproperty
  a_invert: assert property (p_invert) else $error("receive data polarity wrong");

  property p_brk_len;
    s_brk_event |-> (lo_cnt_r == CW'(brk_bits * CW'(BIT_CLKS)) - CW'(1)) && !rx_eff &&
                    (brk_bits == (long_brk_r ? (nine_bit_r ? CW'(12) : CW'(11)) :
                                               (nine_bit_r ? CW'(11) : CW'(10))));
  endproperty
  a_brk_len: assert property (p_brk_len) else $error("break length wrong");

  property p_raf_set;
    s_start_valid |=> o_rx_active;
  endproperty
  a_raf_set: assert property (p_raf_set) else $error("active flag not raised");

  property p_raf_clear;
    (i_ce && state_r == serial_status_pkg::ST_ACTIVE && rx_eff && st_cnt_r >= char_clks - CW'(1))
      |=> !o_rx_active;
  endproperty
  a_raf_clear: assert property (p_raf_clear) else $error("active flag not cleared on idle");

  property p_reset_vals;
    disable iff (1'b0)
    !i_rst_n |=> (!brk_flag_r && !edge_flag_r && !rx_inv_r && !o_rx_active);
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");

endmodule : serial_status_two_flags

/* dv/serial_line_model.sv */
/*
  Remote serial transmitter model that drives the receive line.
  Assumes the bench clock and that the line idles high (mark).
*/
`timescale 1ns/1ps

// ==========================================================
// Remote transmitter
module serial_line_model (
  input  wire logic i_clk,
  output logic      o_line
);
  // Released line reads as mark, as a pulled-up wire would
  initial o_line = 1'b1;

  // One level for n sampling edges, changed just after an edge
  task automatic hold(input logic lvl, input int n);
    @(posedge i_clk);
    o_line <= lvl;
    repeat (n - 1) @(posedge i_clk);
  endtask : hold
endmodule : serial_line_model

/* dv/serial_status_two_flags_tb_top.sv */
/*
  Self-checking bench for the second serial status register.
  Assumes the line model above and a short bit time of 8 clocks.
*/
`timescale 1ns/1ps

// ==========================================================
// Bench top
module serial_status_two_flags_tb_top;
  localparam int BC = 8;
  logic                        i_clk           = 1'b0;
  logic                        i_rst_n         = 1'b0;
  logic                        i_ce            = 1'b1;
  serial_status_pkg::bus_req_t i_bus           = '0;
  logic                        rxd_line;
  logic [7:0]                  o_rdata;
  logic                        o_rx_data;
  logic                        o_err_suppress;
  logic                        o_rx_active;
  int                          err_total       = 0;
  int                          samples_checked = 0;

  // 100 MHz
  always #5 i_clk = ~i_clk;

  serial_status_two_flags #(.BIT_CLKS(BC)) DUT (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_bus(i_bus), .i_rxd(rxd_line),
    .o_rdata(o_rdata), .o_rx_data(o_rx_data), .o_err_suppress(o_err_suppress), .o_rx_active(o_rx_active));

  serial_line_model line (.i_clk(i_clk), .o_line(rxd_line));

  // ==========================================================
  // Shared tasks
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge i_clk);
    i_bus <= '0;
  endtask : bus_wr

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] exp, input logic [7:0] msk);
    @(posedge i_clk);
    i_bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge i_clk);
    i_bus <= '0;
    #1 chk(nm, exp, o_rdata & msk);
  endtask : rd_chk

  // ==========================================================
  // Scenarios
  task automatic t_reset;
    rd_chk("status", 8'h00, 8'h00, 8'hFF);
    rd_chk("control", 8'h01, 8'h00, 8'hFF);
    @(posedge i_clk);
    #1 chk("rdata idle", 8'h00, o_rdata);
    chk("rx_data", 8'h01, {7'h0, o_rx_data});
    chk("suppress", 8'h00, {7'h0, o_err_suppress});
  endtask : t_reset

  // Reserved bits, frozen writes and an unmapped address
  task automatic t_regs;
    bus_wr(8'h00, 8'h2E);
    rd_chk("status rw", 8'h00, 8'h0A, 8'hFF);
    chk("suppress", 8'h01, {7'h0, o_err_suppress});
    @(posedge i_clk);
    i_ce <= 1'b0;
    bus_wr(8'h00, 8'h00);
    i_ce <= 1'b1;
    rd_chk("frozen", 8'h00, 8'h0A, 8'hFF);
    bus_wr(8'h05, 8'hFF);
    rd_chk("unmapped", 8'h05, 8'h00, 8'hFF);
    rd_chk("control", 8'h01, 8'h00, 8'hFF);
    bus_wr(8'h00, 8'h00);
  endtask : t_regs

  // Short low pulse: edge flag but no start bit
  task automatic t_edge;
    line.hold(1'b0, 3);
    #1 chk("rx_data", 8'h00, {7'h0, o_rx_data});
    line.hold(1'b1, 1);
    rd_chk("edge", 8'h00, 8'h40, 8'hFF);
    bus_wr(8'h00, 8'h00);
    rd_chk("w0", 8'h00, 8'h40, 8'hFF);
    bus_wr(8'h00, 8'h80);
    rd_chk("w80", 8'h00, 8'h40, 8'hFF);
    bus_wr(8'h00, 8'h40);
    rd_chk("w40", 8'h00, 8'h00, 8'hFF);
  endtask : t_edge

  // Break thresholds in all four length modes, just below and above
  task automatic t_breaks;
    int         n;
    logic [7:0] lg;
    for (int m = 0; m < 4; m++) begin
      lg = (m >= 2) ? 8'h02 : 8'h00;
      n  = 10 + (m % 2) + m / 2;
      bus_wr(8'h01, 8'h02 | 8'(m % 2));
      bus_wr(8'h00, 8'hC0 | lg);
      line.hold(1'b0, n * BC - 6);
      rd_chk("below", 8'h00, 8'h41 | lg, 8'hFF);
      line.hold(1'b0, BC);
      rd_chk("break", 8'h00, 8'hC1 | lg, 8'hFF);
      chk("suppress", lg >> 1, {7'h0, o_err_suppress});
      bus_wr(8'h00, 8'h40 | lg);
      rd_chk("keep", 8'h00, 8'h81 | lg, 8'hFF);
      line.hold(1'b1, 12 * BC + 4);
      rd_chk("idle", 8'h00, 8'h80 | lg, 8'hFF);
    end
    bus_wr(8'h00, 8'hC0);
    bus_wr(8'h01, 8'h00);
    line.hold(1'b0, 13 * BC);
    rd_chk("brk off", 8'h00, 8'h41, 8'hFF);
    line.hold(1'b1, 12 * BC + 4);
    bus_wr(8'h00, 8'hC0);
  endtask : t_breaks

  // Start bit raises active; exactly ten idle bits clear it
  task automatic t_active;
    line.hold(1'b0, BC - 1);
    #1 chk("active", 8'h01, {7'h0, o_rx_active});
    line.hold(1'b1, 10 * BC - 4);
    #1 chk("still", 8'h01, {7'h0, o_rx_active});
    line.hold(1'b1, BC);
    #1 chk("cleared", 8'h00, {7'h0, o_rx_active});
    bus_wr(8'h00, 8'hC0);
  endtask : t_active

  // Inverted line: high level is a break, rising pin is the active edge
  task automatic t_invert;
    bus_wr(8'h01, 8'h02);
    bus_wr(8'h00, 8'h10);
    @(posedge i_clk);
    #1 chk("inv data", 8'h00, {7'h0, o_rx_data});
    line.hold(1'b1, 11 * BC + 4);
    rd_chk("inv brk", 8'h00, 8'hD1, 8'hFF);
    line.hold(1'b0, 12 * BC + 4);
    #1 chk("inv data", 8'h01, {7'h0, o_rx_data});
    bus_wr(8'h00, 8'hD0);
    rd_chk("inv clr", 8'h00, 8'h10, 8'hFF);
    line.hold(1'b1, 1);
    rd_chk("inv edge", 8'h00, 8'h50, 8'hFE);
  endtask : t_invert

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    repeat (6) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_reset();
    t_regs();
    t_edge();
    t_breaks();
    t_active();
    t_invert();
    end_sim();
  end

  initial begin
    repeat (20000) @(posedge i_clk);
    err_total++;
    $display("wrong value watchdog expected done seen hang");
    end_sim();
  end
endmodule : serial_status_two_flags_tb_top
